// ===== inc/pad_cfg_pkg.sv
// package: register map, field layout and types of the pad configuration bank
`default_nettype none
package pad_cfg_pkg;

  localparam int PIN_COUNT = 4;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [31:0] ADDR_PIN21_PAD_CONFIG = 32'h4004_4030;
  localparam logic [31:0] ADDR_PIN20_PAD_CONFIG = 32'h4004_4058;
  localparam logic [31:0] ADDR_PIN23_PAD_CONFIG = 32'h4004_406C;
  localparam logic [31:0] ADDR_PIN22_PAD_CONFIG = 32'h4004_4070;
  localparam logic [31:0] ADDR_PIN_LEVEL_STATUS = 32'h4004_40F0;

  // pin index of each register
  localparam logic [1:0] IDX_PIN20 = 2'h0;
  localparam logic [1:0] IDX_PIN21 = 2'h1;
  localparam logic [1:0] IDX_PIN22 = 2'h2;
  localparam logic [1:0] IDX_PIN23 = 2'h3;

  // field positions
  localparam int PULL_LSB = 3;
  localparam int PULL_MSB = 4;
  localparam int HYSTERESIS_BIT = 5;
  localparam int INVERT_BIT = 6;
  localparam int RSVD_LSB = 7;
  localparam int RSVD_MSB = 9;
  localparam int OPEN_DRAIN_BIT = 10;

  // reset and fixed values
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic [1:0] PULL_REPEATER = 2'h3;
  localparam logic [1:0] PULL_RESET = PULL_UP;
  localparam logic HYSTERESIS_RESET = 1'h1;
  localparam logic INVERT_RESET = 1'h0;
  localparam logic OPEN_DRAIN_RESET = 1'h0;
  localparam logic [2:0] RSVD_RESET = 3'h1;

  typedef struct packed {
    logic pseudo_open_drain_enable;
    logic input_invert;
    logic hysteresis_enable;
    logic [1:0] pull_mode;
  } pad_cfg_s;

  typedef struct packed {
    logic pull_up_en;
    logic pull_down_en;
    logic repeater_en;
    logic hysteresis_en;
    logic drive_out;
    logic drive_oe;
  } pad_ctrl_s;

  localparam pad_cfg_s CFG_RESET = '{OPEN_DRAIN_RESET, INVERT_RESET, HYSTERESIS_RESET,
    PULL_RESET};

  function automatic logic [DATA_W-1:0] pack_cfg(input pad_cfg_s c);
    logic [DATA_W-1:0] w;
    w = '0;
    w[PULL_MSB:PULL_LSB] = c.pull_mode;
    w[HYSTERESIS_BIT] = c.hysteresis_enable;
    w[INVERT_BIT] = c.input_invert;
    w[RSVD_MSB:RSVD_LSB] = RSVD_RESET;
    w[OPEN_DRAIN_BIT] = c.pseudo_open_drain_enable;
    return w;
  endfunction : pack_cfg

  function automatic pad_cfg_s unpack_cfg(input logic [DATA_W-1:0] w);
    pad_cfg_s c;
    c.pull_mode = w[PULL_MSB:PULL_LSB];
    c.hysteresis_enable = w[HYSTERESIS_BIT];
    c.input_invert = w[INVERT_BIT];
    c.pseudo_open_drain_enable = w[OPEN_DRAIN_BIT];
    return c;
  endfunction : unpack_cfg

endpackage : pad_cfg_pkg
`default_nettype wire

// ===== rtl/pad_cell_ctrl.sv
// per-pin pad control: pull decode, pseudo open-drain drive and input inversion
`timescale 1ns/1ps
`default_nettype none
module pad_cell_ctrl
  import pad_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration
  input wire pad_cfg_s cfg,
  // core side
  input wire logic core_out,
  input wire logic core_dir,
  output logic core_in,
  // pad side
  input wire logic pad_in,
  output pad_ctrl_s pad_ctrl
);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_ctrl <= '{1'b1, 1'b0, 1'b0, HYSTERESIS_RESET, 1'b0, 1'b0};
    end
    else
    begin
      pad_ctrl.pull_up_en <= (cfg.pull_mode == PULL_UP);
      pad_ctrl.pull_down_en <= (cfg.pull_mode == PULL_DOWN);
      pad_ctrl.repeater_en <= (cfg.pull_mode == PULL_REPEATER);
      pad_ctrl.hysteresis_en <= cfg.hysteresis_enable;
      // pseudo open-drain drive
      // emulated: a high is released, not driven; a weak pull must lift the line
      if (cfg.pseudo_open_drain_enable)
      begin
        pad_ctrl.drive_out <= 1'b0;
        pad_ctrl.drive_oe <= core_dir & ~core_out;
      end
      else
      begin
        pad_ctrl.drive_out <= core_out;
        pad_ctrl.drive_oe <= core_dir;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_in <= 1'b0;
    end
    else
    begin
      core_in <= pad_in ^ cfg.input_invert;
    end
  end

endmodule : pad_cell_ctrl
`default_nettype wire

// ===== rtl/pin_pad_config_regs.sv
// apb register bank holding pad configuration for four general-purpose pins
//
// Operation
// - pull field bits 4:3, resets pull-up
// - pull codes: none, down, up, repeater
// - invert clear: pin level read directly
// - invert set: pin level read inverted
// - bit 10 enables emulated open-drain
// - registers decoded at 0x406C and 0x4070
// - registers decoded at 0x4030 and 0x4058
`timescale 1ns/1ps
`default_nettype none
module pin_pad_config_regs
  import pad_cfg_pkg::*;
#(
  parameter int NUM_PINS = PIN_COUNT
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side, index 0..3 = pins 20..23
  input wire logic [NUM_PINS-1:0] core_out,
  input wire logic [NUM_PINS-1:0] core_dir,
  output logic [NUM_PINS-1:0] core_in,
  // pad side
  input wire logic [NUM_PINS-1:0] pad_in,
  output pad_ctrl_s [NUM_PINS-1:0] pad_ctrl
);

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  logic [1:0] pull_reg [NUM_PINS];
  logic [NUM_PINS-1:0] hyst_reg;
  logic [NUM_PINS-1:0] invert_reg;
  logic [NUM_PINS-1:0] open_drain_reg;
  pad_cfg_s pin_cfg [NUM_PINS];
  pad_cfg_s wr_cfg;
  logic [NUM_PINS-1:0] wr_sel;

  logic setup_phase;
  logic access_done;
  logic addr_hit;
  logic cfg_hit;
  logic status_hit;
  logic [1:0] hit_idx;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] merged_wdata;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  function automatic logic [DATA_W-1:0] strobe_merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [3:0] strb
  );
    logic [DATA_W-1:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction : strobe_merge

  // address decode
  always_comb
  begin
    cfg_hit = 1'b1;
    status_hit = 1'b0;
    hit_idx = IDX_PIN20;
    case (paddr)
      ADDR_PIN23_PAD_CONFIG:
      begin
        hit_idx = IDX_PIN23;
      end
      ADDR_PIN22_PAD_CONFIG:
      begin
        hit_idx = IDX_PIN22;
      end
      ADDR_PIN21_PAD_CONFIG:
      begin
        hit_idx = IDX_PIN21;
      end
      ADDR_PIN20_PAD_CONFIG:
      begin
        hit_idx = IDX_PIN20;
      end
      ADDR_PIN_LEVEL_STATUS:
      begin
        cfg_hit = 1'b0;
        status_hit = 1'b1;
      end
      default:
      begin
        cfg_hit = 1'b0;
      end
    endcase
  end

  assign addr_hit = cfg_hit | status_hit;
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;

  // one wait-free answer: pready rises in the access phase
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= setup_phase;
    end
  end

  // status register is read-only, so a write to it is flagged as well
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      pslverr <= ~addr_hit | (status_hit & pwrite);
    end
    else
    begin
      pslverr <= 1'b0;
    end
  end

  // read data
  always_comb
  begin
    rdata_next = '0;
    if (cfg_hit)
    begin
      rdata_next = pack_cfg(pin_cfg[hit_idx]);
    end
    else if (status_hit)
    begin
      rdata_next[NUM_PINS-1:0] = core_in;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= '0;
    end
    else if (setup_phase & ~pwrite)
    begin
      prdata <= rdata_next;
    end
    else if (access_done)
    begin
      prdata <= '0;
    end
  end

  assign merged_wdata = strobe_merge(pack_cfg(pin_cfg[hit_idx]), pwdata, pstrb);
  assign wr_cfg = unpack_cfg(merged_wdata);

  // only a completed access phase commits, so a refused setup never writes
  always_comb
  begin
    wr_sel = '0;
    if (access_done & pwrite & cfg_hit)
    begin
      wr_sel[hit_idx] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
        pull_reg[i] <= CFG_RESET.pull_mode;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
        if (wr_sel[i])
        begin
          pull_reg[i] <= wr_cfg.pull_mode;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hyst_reg <= {NUM_PINS{CFG_RESET.hysteresis_enable}};
    end
    else
    begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
        if (wr_sel[i])
        begin
          hyst_reg[i] <= wr_cfg.hysteresis_enable;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      invert_reg <= {NUM_PINS{CFG_RESET.input_invert}};
    end
    else
    begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
        if (wr_sel[i])
        begin
          invert_reg[i] <= wr_cfg.input_invert;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      open_drain_reg <= {NUM_PINS{CFG_RESET.pseudo_open_drain_enable}};
    end
    else
    begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
        if (wr_sel[i])
        begin
          open_drain_reg[i] <= wr_cfg.pseudo_open_drain_enable;
        end
      end
    end
  end

  // fields kept in separate flops so each concern has a single writer
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      pin_cfg[i].pull_mode = pull_reg[i];
      pin_cfg[i].hysteresis_enable = hyst_reg[i];
      pin_cfg[i].input_invert = invert_reg[i];
      pin_cfg[i].pseudo_open_drain_enable = open_drain_reg[i];
    end
  end

  // one pad controller per pin
  for (genvar p = 0; p < NUM_PINS; p++)
  begin : g_pad
    pad_cell_ctrl u_pad (
      .clk(sys_clk),
      .rst_n(rst_n),
      .cfg(pin_cfg[p]),
      .core_out(core_out[p]),
      .core_dir(core_dir[p]),
      .core_in(core_in[p]),
      .pad_in(pad_in[p]),
      .pad_ctrl(pad_ctrl[p])
    );
  end

endmodule : pin_pad_config_regs
`default_nettype wire

// ===== dv/pad_cell_model.sv
// pad cell model: resolves the pin level from drive, outside source and pulls
`timescale 1ns/1ps
`default_nettype none
module pad_cell_model
  import pad_cfg_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // pad control from the bank
  input wire pad_ctrl_s ctrl,
  // outside source
  input wire logic ext_en,
  input wire logic ext_lvl,
  // pin level
  output logic pad_lvl
);
  logic last_reg;
  always_ff @(posedge sys_clk)
  begin
    last_reg <= pad_lvl;
  end
  // drive and pulls
  // a floating pin flips every cycle so a guessed level never passes
  always_comb
  begin
    if (ctrl.drive_oe) pad_lvl = ctrl.drive_out;
    else if (ext_en) pad_lvl = ext_lvl;
    else if (ctrl.pull_up_en) pad_lvl = 1'b1;
    else if (ctrl.pull_down_en) pad_lvl = 1'b0;
    else if (ctrl.repeater_en) pad_lvl = last_reg;
    else pad_lvl = ~last_reg;
  end
endmodule : pad_cell_model
`default_nettype wire

// ===== dv/pin_pad_config_regs_assertions.sv
// checker: apb answers and pad control relations of the pad bank
`timescale 1ns/1ps
`default_nettype none
module pin_pad_config_regs_assertions
  import pad_cfg_pkg::*;
#(
  parameter int NUM_PINS = PIN_COUNT
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [NUM_PINS-1:0] core_out,
  input wire logic [NUM_PINS-1:0] core_dir,
  input wire pad_ctrl_s [NUM_PINS-1:0] pad_ctrl
);
  logic hit;
  assign hit = paddr inside {ADDR_PIN20_PAD_CONFIG, ADDR_PIN21_PAD_CONFIG,
    ADDR_PIN22_PAD_CONFIG, ADDR_PIN23_PAD_CONFIG};
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_done_s;
    psel && penable && pready && !pwrite;
  endsequence
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  mapped_ok_a: assert property (setup_s ##0 hit |=> pready && !pslverr)
    else $error("mapped access not answered");
  unmapped_err_a: assert property (setup_s ##0 !hit && (pwrite || paddr != ADDR_PIN_LEVEL_STATUS)
    |=> pready && pslverr && prdata == 32'h0) else $error("bad access accepted");
  rsvd_read_a: assert property (rd_done_s ##0 hit |-> prdata[31:11] == 21'h0
    && prdata[9:7] == 3'h1 && prdata[2:0] == 3'h0) else $error("reserved bits wrong");
  pull_onehot_a: assert property ($onehot0({pad_ctrl[0].pull_up_en, pad_ctrl[0].pull_down_en,
    pad_ctrl[0].repeater_en})) else $error("pull selects overlap");
  reset_pull_a: assert property ($rose(nrst) |-> pad_ctrl[0].pull_up_en)
    else $error("pull-up missing at reset");
  oe_cause_a: assert property (pad_ctrl[0].drive_oe |-> $past(core_dir[0]))
    else $error("drive without direction");
  drive_cause_a: assert property (pad_ctrl[0].drive_out |-> $past(core_out[0]))
    else $error("drive level without cause");
  reset_hyst_a: assert property ($rose(nrst) |-> pad_ctrl[0].hysteresis_en)
    else $error("hysteresis missing at reset");
  status_ok_a: assert property (setup_s ##0 !pwrite && paddr == ADDR_PIN_LEVEL_STATUS
    |=> pready && !pslverr) else $error("status read refused");
endmodule : pin_pad_config_regs_assertions
bind pin_pad_config_regs pin_pad_config_regs_assertions #(.NUM_PINS(NUM_PINS)) u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_out(core_out), .core_dir(core_dir), .pad_ctrl(pad_ctrl));
`default_nettype wire

// ===== dv/pin_pad_config_regs_tb_top.sv
// testbench: pad configuration bank against a behavioural register model
`timescale 1ns/1ps
`default_nettype none
module pin_pad_config_regs_tb_top
  import pad_cfg_pkg::*;
;
  logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, r, d;
  logic [3:0] pstrb, core_out, core_dir, core_in, pad_in, ext_en, ext_lvl;
  pad_ctrl_s [3:0] pad_ctrl;
  logic [31:0] adr [4];
  logic [31:0] m [4];
  int failures = 0;
  int n_tests = 0;
  pin_pad_config_regs DUT (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_out(core_out), .core_dir(core_dir),
    .core_in(core_in), .pad_in(pad_in), .pad_ctrl(pad_ctrl));
  for (genvar i = 0; i < 4; i++)
  begin : g_pad
    pad_cell_model u_pad (.sys_clk(sys_clk), .ctrl(pad_ctrl[i]), .ext_en(ext_en[i]),
      .ext_lvl(ext_lvl[i]), .pad_lvl(pad_in[i]));
  end
  initial
  begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic cmp_data(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x)
    begin
      failures++;
      $display("unexpected data at %0t: got %h exp %h", $time, g, x);
    end
  endtask : cmp_data
  task automatic cmp_err(input logic g, input logic x);
    n_tests++;
    if (g !== x)
    begin
      failures++;
      $display("unexpected error flag at %0t: got %h exp %h", $time, g, x);
    end
  endtask : cmp_err
  task automatic cmp_pad(input pad_ctrl_s g, input pad_ctrl_s x);
    n_tests++;
    if (g !== x)
    begin
      failures++;
      $display("unexpected pad control at %0t: got %h exp %h", $time, g, x);
    end
  endtask : cmp_pad
  task automatic cmp_lvl(input logic g, input logic x);
    n_tests++;
    if (g !== x)
    begin
      failures++;
      $display("unexpected input level at %0t: got %h exp %h", $time, g, x);
    end
  endtask : cmp_lvl
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
    input logic [3:0] s);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    // no wait limit here: only the watchdog ends a hung access
    while (pready !== 1'b1)
    begin
      @(posedge sys_clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rd(input int i);
    apb(1'b0, adr[i], 32'h0, 4'h0);
    cmp_data(r, m[i]);
  endtask : rd
  // only pull, hysteresis, invert and open-drain bits take writes, per byte lane
  task automatic wr(input int i, input logic [31:0] wd, input logic [3:0] s);
    logic [31:0] k;
    k = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & 32'h0000_0478;
    m[i] = (m[i] & ~k) | (wd & k);
    apb(1'b1, adr[i], wd, s);
    cmp_err(e, 1'b0);
    rd(i);
  endtask : wr
  task automatic pins;
    logic [1:0] c;
    logic [5:0] x;
    logic l;
    logic [3:0] lv;
    logic [3:0] dm;
    lv = '0;
    dm = '0;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 4; i++)
    begin
      c = m[i][4:3];
      x = {c == 2'h2, c == 2'h1, c == 2'h3, m[i][5], ~m[i][10] & core_out[i],
        core_dir[i] & (~m[i][10] | ~core_out[i])};
      cmp_pad(pad_ctrl[i], x);
      l = x[0] ? x[1] : (ext_en[i] ? ext_lvl[i] : c[1]);
      if (x[0] | ext_en[i] | (c == 2'h1) | (c == 2'h2))
      begin
        dm[i] = 1'b1;
        lv[i] = l ^ m[i][6];
        cmp_lvl(core_in[i], lv[i]);
      end
    end
    // floating pins toggle in the model, so only settled levels are compared
    apb(1'b0, ADDR_PIN_LEVEL_STATUS, 32'h0, 4'h0);
    cmp_err(e, 1'b0);
    cmp_data(r & {28'hFFF_FFFF, dm}, {28'h0, lv});
  endtask : pins
  initial
  begin
    #250000;
    failures++;
    conclude();
  end
  initial
  begin
    adr = '{ADDR_PIN20_PAD_CONFIG, ADDR_PIN21_PAD_CONFIG, ADDR_PIN22_PAD_CONFIG,
      ADDR_PIN23_PAD_CONFIG};
    {nrst, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {core_out, core_dir, ext_en, ext_lvl} = '0;
    void'($urandom(32'hF729));
    for (int t = 0; t < 2; t++)
    begin
      for (int i = 0; i < 4; i++) m[i] = 32'hB0;
      repeat (5) @(posedge sys_clk);
      nrst <= 1;
      repeat (3) @(posedge sys_clk);
      pins();
      for (int i = 0; i < 4; i++) rd(i);
      $display("reset test %0d done", t);
      for (int n = 0; n < 32 && t == 0; n++)
      begin
        d = $urandom;
        d[4:3] = 2'(n % 4);
        wr(n % 4, d, 4'hF);
        ext_en <= 4'($urandom);
        ext_lvl <= 4'($urandom);
        core_dir <= 4'($urandom);
        core_out <= 4'($urandom);
        pins();
      end
      $display("field test done");
      wr(1, 32'hFFFF_FFFF, 4'h2);
      wr(2, 32'h0, 4'h1);
      pins();
      apb(1'b1, 32'h4004_4034, 32'hFFFF_FFFF, 4'hF);
      cmp_err(e, 1'b1);
      apb(1'b0, 32'h4004_406D, 32'h0, 4'h0);
      cmp_err(e, 1'b1);
      cmp_data(r, 32'h0);
      apb(1'b1, ADDR_PIN_LEVEL_STATUS, 32'hF, 4'hF);
      cmp_err(e, 1'b1);
      for (int i = 0; i < 4; i++) rd(i);
      $display("error test done");
      nrst <= 0;
    end
    conclude();
  end
endmodule : pin_pad_config_regs_tb_top
`default_nettype wire
